//--- hdl/tsoi_defs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef TSOI_DEFS_SVH
`define TSOI_DEFS_SVH
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define TSOI_OFF_CTRL 12'h000
`define TSOI_OFF_STATUS 12'h004
`define TSOI_OFF_IRQ_STAT 12'h008
`define TSOI_OFF_IRQ_MASK 12'h00C
`define TSOI_OFF_BAUD_DIV 12'h010
`define TSOI_OFF_RESULT 12'h014
// ****************************************************************
// Control register fields (self-clearing command bits)
// ****************************************************************
`define TSOI_CTRL_OUT_ON 0
`define TSOI_CTRL_OUT_OFF 1
`define TSOI_CTRL_TEST_START 2
`define TSOI_CTRL_TEST_PASS 3
`define TSOI_CTRL_TEST_FAIL 4
// ****************************************************************
// Status register fields
// ****************************************************************
`define TSOI_ST_OUTPUT 0
`define TSOI_ST_PASS 1
`define TSOI_ST_FAIL 2
`define TSOI_ST_BUSY 3
`define TSOI_ST_LOOP 4
`define TSOI_ST_RX_VALID 5
`define TSOI_ST_TX_BUSY 6
// ****************************************************************
// Interrupt event bits
// ****************************************************************
`define TSOI_EV_REFUSED 0
`define TSOI_EV_LOOP_OPEN 1
`define TSOI_EV_TEST_DONE 2
`define TSOI_EV_CMD_END 3
`define TSOI_EV_RX_ERR 4
`define TSOI_EV_WIDTH 5
// ****************************************************************
// Result register fields and reply bytes
// ****************************************************************
`define TSOI_RES_ACK 0
`define TSOI_RES_NAK 1
`define TSOI_BYTE_ACK 8'h06
`define TSOI_BYTE_NAK 8'h15
`define TSOI_BYTE_LF 8'h0A
// ****************************************************************
// Timing: 9600 baud at a 50 MHz clock
// ****************************************************************
`define TSOI_CLK_HZ 50000000
`define TSOI_BAUD 9600
`define TSOI_BAUD_DIV_RST (`TSOI_CLK_HZ / `TSOI_BAUD)
`define TSOI_DATA_BITS 8
`define TSOI_STOP_BITS 1
`endif

//--- hdl/tsoi_pkg.sv
// Types shared by the status, output and interlock block.
package tsoi_pkg;
   typedef enum logic [1:0] {TSOI_IDLE, TSOI_START, TSOI_DATA, TSOI_STOP}
      tsoi_uart_state_t;
endpackage

//--- hdl/tsoi_top.sv
// Output-on indicator, status contacts, interlock gate and serial reply.
//
// Notes on behaviour
// - Indicator line high exactly while output on.
// - Pass contact closes on pass, opens at start.
// - Fail contact closes on fail, opens at start.
// - Busy contact closes at start, opens when done.
// - Output stays off unless interlock loop closed.
// - Port defaults to 9600 baud, 8N1.
// - No XON/XOFF and no handshake lines.
// - Successful command answered with byte 0x06.
// - Faulty command answered with byte 0x15.
`timescale 1ns/1ps
`include "tsoi_defs.svh"
module tsoi_top #(
   parameter int DIV_W = 16,
   parameter logic [DIV_W-1:0] BAUD_DIV_RST = DIV_W'(`TSOI_BAUD_DIV_RST)
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Local front-panel requests, one-cycle pulses.
   input wire logic local_out_on,
   input wire logic local_out_off,
   // Interlock loop, high while the two pins are shorted.
   input wire logic interlock_closed,
   // Indicator and status contacts, high means closed.
   output logic output_on_ind,
   output logic pass_contact,
   output logic fail_contact,
   output logic busy_contact,
   // Serial port.
   input wire logic rxd,
   output logic txd,
   // Received command bytes for the command firmware.
   output logic [7:0] cmd_byte,
   output logic cmd_byte_valid,
   output logic cmd_end,
   // Interrupt.
   output logic irq
);
   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic [11:0] addr_reg;
   logic wr_reg;
   logic rd_reg;
   logic [`TSOI_EV_WIDTH-1:0] irq_stat_reg;
   logic [`TSOI_EV_WIDTH-1:0] irq_mask_reg;
   logic [DIV_W-1:0] baud_div_reg;
   logic power_on_reg;
   logic [7:0] rx_data;
   logic rx_strobe;
   logic rx_error;
   logic tx_busy;
   logic tx_start;
   logic [7:0] tx_data;
   logic reply_pend_reg;
   logic [7:0] reply_byte_reg;
   logic rx_avail_reg;
   logic [31:0] status_word;
   logic wr_ctrl;
   logic wr_result;
   logic on_req;
   logic off_req;
   logic refused;
   logic loop_drop;
   logic test_done;
   logic [`TSOI_EV_WIDTH-1:0] events;

   // Capture the address phase; every transfer finishes with no wait.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         addr_reg <= 12'h000;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
      end else begin
         wr_reg <= hsel && hready && htrans[1] && hwrite;
         rd_reg <= hsel && hready && htrans[1] && !hwrite;
         if (hsel && hready && htrans[1]) begin
            addr_reg <= haddr;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_ctrl = wr_reg && (addr_reg == `TSOI_OFF_CTRL);
   assign wr_result = wr_reg && (addr_reg == `TSOI_OFF_RESULT);

   // Status word gathers the block's own state.
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`TSOI_ST_OUTPUT] = power_on_reg;
      status_word[`TSOI_ST_PASS] = pass_contact;
      status_word[`TSOI_ST_FAIL] = fail_contact;
      status_word[`TSOI_ST_BUSY] = busy_contact;
      status_word[`TSOI_ST_LOOP] = interlock_closed;
      status_word[`TSOI_ST_RX_VALID] = rx_avail_reg;
      status_word[`TSOI_ST_TX_BUSY] = tx_busy || reply_pend_reg;
   end

   // Read data is combinational in the data phase; unmapped reads zero.
   always_comb begin
      hrdata = 32'h0000_0000;
      if (rd_reg) begin
         case (addr_reg)
            `TSOI_OFF_STATUS: hrdata = status_word;
            `TSOI_OFF_IRQ_STAT: hrdata = 32'(irq_stat_reg);
            `TSOI_OFF_IRQ_MASK: hrdata = 32'(irq_mask_reg);
            `TSOI_OFF_BAUD_DIV: hrdata = 32'(baud_div_reg);
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Mask and bit period; the period resets to BAUD_DIV_RST, the 9600 baud value by default.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_mask_reg <= '0;
         baud_div_reg <= BAUD_DIV_RST;
      end else if (wr_reg) begin
         if (addr_reg == `TSOI_OFF_IRQ_MASK) begin
            irq_mask_reg <= hwdata[`TSOI_EV_WIDTH-1:0];
         end
         if (addr_reg == `TSOI_OFF_BAUD_DIV && hwdata[DIV_W-1:0] > 1) begin
            baud_div_reg <= hwdata[DIV_W-1:0];
         end
      end
   end

   // ****************************************************************
   // Output control and interlock
   // ****************************************************************
   assign on_req = local_out_on || (wr_ctrl && hwdata[`TSOI_CTRL_OUT_ON]);
   assign off_req = local_out_off || (wr_ctrl && hwdata[`TSOI_CTRL_OUT_OFF]);
   assign refused = on_req && !off_req && !interlock_closed;
   assign loop_drop = power_on_reg && !interlock_closed;

   // An open loop also drops a running output, so it can never stay on.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         power_on_reg <= 1'b0;
      end else if (off_req || !interlock_closed) begin
         power_on_reg <= 1'b0;
      end else if (on_req) begin
         power_on_reg <= 1'b1;
      end
   end

   assign output_on_ind = power_on_reg;

   // ****************************************************************
   // Test status contacts
   // ****************************************************************
   assign test_done = busy_contact && wr_ctrl &&
      (hwdata[`TSOI_CTRL_TEST_PASS] || hwdata[`TSOI_CTRL_TEST_FAIL]);

   // Start clears both results in the same edge the busy contact closes,
   // so no cycle shows pass and fail together; fail beats pass if both.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pass_contact <= 1'b0;
         fail_contact <= 1'b0;
         busy_contact <= 1'b0;
      end else if (wr_ctrl && hwdata[`TSOI_CTRL_TEST_START]) begin
         pass_contact <= 1'b0;
         fail_contact <= 1'b0;
         busy_contact <= 1'b1;
      end else if (test_done) begin
         busy_contact <= 1'b0;
         fail_contact <= hwdata[`TSOI_CTRL_TEST_FAIL];
         pass_contact <= !hwdata[`TSOI_CTRL_TEST_FAIL];
      end
   end

   // ****************************************************************
   // Serial port and reply bytes
   // ****************************************************************
   tsoi_uart #(
      .DIV_W(DIV_W)
   ) u_uart (
      .clk(clk),
      .reset_n(reset_n),
      .baud_div(baud_div_reg),
      .rxd(rxd),
      .txd(txd),
      .rx_data(rx_data),
      .rx_strobe(rx_strobe),
      .rx_error(rx_error),
      .tx_data(tx_data),
      .tx_start(tx_start),
      .tx_busy(tx_busy)
   );

   // Received bytes go straight out; a line feed marks the end.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cmd_byte <= 8'h00;
         cmd_byte_valid <= 1'b0;
         cmd_end <= 1'b0;
         rx_avail_reg <= 1'b0;
      end else begin
         cmd_byte_valid <= rx_strobe;
         cmd_end <= rx_strobe && (rx_data == `TSOI_BYTE_LF);
         if (rx_strobe) begin
            cmd_byte <= rx_data;
         end
         if (rx_strobe && rx_data == `TSOI_BYTE_LF) begin
            rx_avail_reg <= 1'b0;
         end else if (rx_strobe) begin
            rx_avail_reg <= 1'b1;
         end
      end
   end

   // One reply is held at a time; a later result overwrites it.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reply_pend_reg <= 1'b0;
         reply_byte_reg <= `TSOI_BYTE_ACK;
      end else if (wr_result && hwdata[`TSOI_RES_NAK]) begin
         reply_pend_reg <= 1'b1;
         reply_byte_reg <= `TSOI_BYTE_NAK;
      end else if (wr_result && hwdata[`TSOI_RES_ACK]) begin
         reply_pend_reg <= 1'b1;
         reply_byte_reg <= `TSOI_BYTE_ACK;
      end else if (tx_start) begin
         reply_pend_reg <= 1'b0;
      end
   end

   assign tx_start = reply_pend_reg && !tx_busy;
   assign tx_data = reply_byte_reg;

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   always_comb begin
      events = '0;
      events[`TSOI_EV_REFUSED] = refused;
      events[`TSOI_EV_LOOP_OPEN] = loop_drop;
      events[`TSOI_EV_TEST_DONE] = test_done;
      events[`TSOI_EV_CMD_END] = rx_strobe && (rx_data == `TSOI_BYTE_LF);
      events[`TSOI_EV_RX_ERR] = rx_error;
   end

   // Write one to clear; an event in the same cycle keeps its bit set.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_stat_reg <= '0;
      end else if (wr_reg && addr_reg == `TSOI_OFF_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~hwdata[`TSOI_EV_WIDTH-1:0]) |
            events;
      end else begin
         irq_stat_reg <= irq_stat_reg | events;
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule

//--- hdl/tsoi_uart.sv
// Serial port without flow control: 8 data bits, no parity, 1 stop bit.
`timescale 1ns/1ps
`include "tsoi_defs.svh"
module tsoi_uart #(
   parameter int DIV_W = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Bit period in clock cycles.
   input wire logic [DIV_W-1:0] baud_div,
   // Serial lines.
   input wire logic rxd,
   output logic txd,
   // Received byte, one-cycle strobe.
   output logic [7:0] rx_data,
   output logic rx_strobe,
   output logic rx_error,
   // Byte to send.
   input wire logic [7:0] tx_data,
   input wire logic tx_start,
   output logic tx_busy
);
   tsoi_pkg::tsoi_uart_state_t rx_state_reg;
   tsoi_pkg::tsoi_uart_state_t tx_state_reg;
   logic [DIV_W-1:0] rx_cnt_reg;
   logic [DIV_W-1:0] tx_cnt_reg;
   logic [2:0] rx_bit_reg;
   logic [2:0] tx_bit_reg;
   logic [7:0] rx_sh_reg;
   logic [7:0] tx_sh_reg;
   logic rx_meta_reg;
   logic rx_sync_reg;

   // Two flops keep the asynchronous line from upsetting the receiver.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end else begin
         rx_meta_reg <= rxd;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // Receiver samples mid-bit; no pause is ever requested of the host.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_state_reg <= tsoi_pkg::TSOI_IDLE;
         rx_cnt_reg <= '0;
         rx_bit_reg <= 3'd0;
         rx_sh_reg <= 8'h00;
         rx_data <= 8'h00;
         rx_strobe <= 1'b0;
         rx_error <= 1'b0;
      end else begin
         rx_strobe <= 1'b0;
         rx_error <= 1'b0;
         case (rx_state_reg)
            tsoi_pkg::TSOI_IDLE: begin
               rx_cnt_reg <= baud_div >> 1;
               if (!rx_sync_reg) begin
                  rx_state_reg <= tsoi_pkg::TSOI_START;
               end
            end
            tsoi_pkg::TSOI_START: begin
               if (rx_cnt_reg == '0) begin
                  rx_cnt_reg <= baud_div - 1'b1;
                  rx_bit_reg <= 3'd0;
                  // A start bit that vanished was a glitch.
                  rx_state_reg <= rx_sync_reg ? tsoi_pkg::TSOI_IDLE
                                              : tsoi_pkg::TSOI_DATA;
               end else begin
                  rx_cnt_reg <= rx_cnt_reg - 1'b1;
               end
            end
            tsoi_pkg::TSOI_DATA: begin
               if (rx_cnt_reg == '0) begin
                  rx_cnt_reg <= baud_div - 1'b1;
                  rx_sh_reg <= {rx_sync_reg, rx_sh_reg[7:1]};
                  rx_bit_reg <= rx_bit_reg + 3'd1;
                  if (rx_bit_reg == 3'd7) begin
                     rx_state_reg <= tsoi_pkg::TSOI_STOP;
                  end
               end else begin
                  rx_cnt_reg <= rx_cnt_reg - 1'b1;
               end
            end
            tsoi_pkg::TSOI_STOP: begin
               if (rx_cnt_reg == '0) begin
                  rx_state_reg <= tsoi_pkg::TSOI_IDLE;
                  if (rx_sync_reg) begin
                     rx_data <= rx_sh_reg;
                     rx_strobe <= 1'b1;
                  end else begin
                     rx_error <= 1'b1;
                  end
               end else begin
                  rx_cnt_reg <= rx_cnt_reg - 1'b1;
               end
            end
            default: rx_state_reg <= tsoi_pkg::TSOI_IDLE;
         endcase
      end
   end

   // Transmitter: start bit, eight data bits LSB first, one stop bit.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_state_reg <= tsoi_pkg::TSOI_IDLE;
         tx_cnt_reg <= '0;
         tx_bit_reg <= 3'd0;
         tx_sh_reg <= 8'h00;
         txd <= 1'b1;
      end else begin
         case (tx_state_reg)
            tsoi_pkg::TSOI_IDLE: begin
               txd <= 1'b1;
               if (tx_start) begin
                  tx_sh_reg <= tx_data;
                  tx_cnt_reg <= baud_div - 1'b1;
                  txd <= 1'b0;
                  tx_state_reg <= tsoi_pkg::TSOI_START;
               end
            end
            tsoi_pkg::TSOI_START, tsoi_pkg::TSOI_DATA: begin
               if (tx_cnt_reg == '0) begin
                  tx_cnt_reg <= baud_div - 1'b1;
                  if (tx_state_reg == tsoi_pkg::TSOI_START) begin
                     tx_bit_reg <= 3'd0;
                     txd <= tx_sh_reg[0];
                     tx_state_reg <= tsoi_pkg::TSOI_DATA;
                  end else if (tx_bit_reg == 3'd7) begin
                     txd <= 1'b1;
                     tx_state_reg <= tsoi_pkg::TSOI_STOP;
                  end else begin
                     tx_bit_reg <= tx_bit_reg + 3'd1;
                     txd <= tx_sh_reg[tx_bit_reg + 3'd1];
                  end
               end else begin
                  tx_cnt_reg <= tx_cnt_reg - 1'b1;
               end
            end
            tsoi_pkg::TSOI_STOP: begin
               if (tx_cnt_reg == '0) begin
                  tx_state_reg <= tsoi_pkg::TSOI_IDLE;
               end else begin
                  tx_cnt_reg <= tx_cnt_reg - 1'b1;
               end
            end
            default: tx_state_reg <= tsoi_pkg::TSOI_IDLE;
         endcase
      end
   end

   assign tx_busy = (tx_state_reg != tsoi_pkg::TSOI_IDLE);
endmodule

//--- test/tsoi_host.sv
// Host serial port model: sends command bytes and decodes replies.
`timescale 1ns/1ps
module tsoi_host #(
   parameter int BIT = 8
) (
   // Clock.
   input wire logic clk,
   // Serial lines seen from the host.
   input wire logic txd,
   output logic rxd,
   // Last reply byte and number of replies.
   output logic [7:0] reply,
   output int n_reply
);
   logic [7:0] sh;
   // Line idles high between frames.
   initial begin
      rxd = 1'b1;
      reply = 8'h00;
      n_reply = 0;
   end
   // Frames go out 8N1, low bit first; no handshake is waited on, since
   // the device offers none.
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT) @(posedge clk);
      end
   endtask
   // Replies are sampled mid-bit; a start bit that is gone by mid-bit is
   // taken for a glitch.
   always begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk);
      if (txd == 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            sh[i] = txd;
         end
         repeat (BIT) @(posedge clk);
         reply <= sh;
         n_reply <= n_reply + 1;
      end
   end
endmodule

//--- test/tsoi_top_bench.sv
// Self-checking bench of the status, output and interlock block.
`timescale 1ns/1ps
`include "tsoi_defs.svh"
module tsoi_top_bench;
   logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic local_out_on, local_out_off, interlock_closed, irq;
   logic output_on_ind, pass_contact, fail_contact, busy_contact;
   logic rxd, txd, cmd_byte_valid, cmd_end;
   logic [7:0] cmd_byte, reply;
   int n_reply, checks, n_mismatch;
   // ****************************************************************
   // Design, host model and clock
   // ****************************************************************
   tsoi_top #(.BAUD_DIV_RST(16'h0008)) DUT (.clk(clk), .reset_n(reset_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .local_out_on(local_out_on),
      .local_out_off(local_out_off), .interlock_closed(interlock_closed),
      .output_on_ind(output_on_ind), .pass_contact(pass_contact),
      .fail_contact(fail_contact), .busy_contact(busy_contact),
      .rxd(rxd), .txd(txd), .cmd_byte(cmd_byte),
      .cmd_byte_valid(cmd_byte_valid), .cmd_end(cmd_end), .irq(irq));
   tsoi_host #(.BIT(8)) host (.clk(clk), .txd(txd), .rxd(rxd),
      .reply(reply), .n_reply(n_reply));
   // The single slave's ready is the bus ready.
   assign hready = hreadyout;
   // A 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // One single word transfer; entered just after a rising edge.
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
      repeat (2) @(posedge clk);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a,
      input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0000_0000, x);
      check(what, x, e);
   endtask
   task automatic press(input logic on);
      if (on) local_out_on <= 1'b1;
      else local_out_off <= 1'b1;
      @(posedge clk);
      local_out_on <= 1'b0;
      local_out_off <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic loop(input logic c);
      interlock_closed <= c;
      repeat (4) @(posedge clk);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      check("contacts", {output_on_ind, pass_contact, fail_contact,
         busy_contact, txd, irq}, 32'h0000_0002);
      rd_chk("mask", `TSOI_OFF_IRQ_MASK, 32'h0000_0000);
      rd_chk("divider", `TSOI_OFF_BAUD_DIV, 32'h0000_0008);
      rd_chk("status", `TSOI_OFF_STATUS, 32'h0000_0000);
      wr(12'h020, 32'hFFFF_FFFF);
      rd_chk("unmapped", 12'h020, 32'h0000_0000);
   endtask
   // Refusals with the loop open raise an event that is masked, then
   // unmasked and cleared.
   task automatic t_interlock();
      press(1'b1);
      check("panel on, loop open", output_on_ind, 1'b0);
      wr(`TSOI_OFF_CTRL, 32'h0000_0001);
      check("remote on, loop open", output_on_ind, 1'b0);
      rd_chk("refused event", `TSOI_OFF_IRQ_STAT, 32'h0000_0001);
      check("irq masked", irq, 1'b0);
      wr(`TSOI_OFF_IRQ_MASK, 32'h0000_0001);
      check("irq raised", irq, 1'b1);
      wr(`TSOI_OFF_IRQ_STAT, 32'h0000_001F);
      check("irq cleared", irq, 1'b0);
      loop(1'b1);
      wr(`TSOI_OFF_CTRL, 32'h0000_0001);
      check("remote on", output_on_ind, 1'b1);
      rd_chk("status on", `TSOI_OFF_STATUS, 32'h0000_0011);
      loop(1'b0);
      check("loop opened", output_on_ind, 1'b0);
      rd_chk("open event", `TSOI_OFF_IRQ_STAT, 32'h0000_0002);
      loop(1'b1);
      press(1'b1);
      check("panel on", output_on_ind, 1'b1);
      press(1'b0);
      check("panel off", output_on_ind, 1'b0);
   endtask
   // A pass without a test, then pass, fail and pass runs back to back.
   task automatic t_tests();
      logic [4:0] cmd [7] = '{8, 4, 8, 4, 16, 4, 8};
      logic [2:0] exp [7] = '{0, 1, 4, 1, 2, 1, 4};
      for (int i = 0; i < 7; i++) begin
         wr(`TSOI_OFF_CTRL, {27'h0, cmd[i]});
         check("pass fail busy", {pass_contact, fail_contact,
            busy_contact}, exp[i]);
      end
      // Loop-open event is still pending from the interlock scenario.
      rd_chk("done event", `TSOI_OFF_IRQ_STAT, 32'h0000_0006);
   endtask
   // A command with its line feed, then ACK, NAK and both requested.
   task automatic t_serial();
      logic [1:0] res [3] = '{1, 2, 3};
      logic [7:0] exp [3] = '{8'h06, 8'h15, 8'h15};
      int n0;
      wr(`TSOI_OFF_IRQ_STAT, 32'h0000_001F);
      host.send_byte(8'h41);
      host.send_byte(8'h0A);
      repeat (4) @(posedge clk);
      check("last byte", cmd_byte, 8'h0A);
      rd_chk("end event", `TSOI_OFF_IRQ_STAT, 32'h0000_0008);
      for (int i = 0; i < 3; i++) begin
         n0 = n_reply;
         wr(`TSOI_OFF_RESULT, {30'h0, res[i]});
         for (int k = 0; k < 400 && n_reply == n0; k++) @(posedge clk);
         check("reply count", n_reply, n0 + 1);
         check("reply", reply, exp[i]);
      end
   endtask
   // Inputs start idle; reset is held for three cycles.
   initial begin
      checks = 0;
      n_mismatch = 0;
      reset_n <= 1'b0;
      hsel <= 1'b1;
      hsize <= 3'b010;
      htrans <= 2'b00;
      haddr <= 12'h000;
      hwrite <= 1'b0;
      hwdata <= 32'h0000_0000;
      local_out_on <= 1'b0;
      local_out_off <= 1'b0;
      interlock_closed <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_interlock();
      t_tests();
      t_serial();
      end_of_test();
   end
   // The tests need under a thousand cycles; this cuts a hang short.
   initial begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
endmodule

//--- test/tsoi_top_sva.sv
// Checker for the indicator, status contacts and serial reply.
`timescale 1ns/1ps
module tsoi_top_sva (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Front panel and interlock.
   input wire logic local_out_on,
   input wire logic local_out_off,
   input wire logic interlock_closed,
   // Indicator and contacts.
   input wire logic output_on_ind,
   input wire logic pass_contact,
   input wire logic fail_contact,
   input wire logic busy_contact,
   // Serial side and bus response.
   input wire logic txd,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_byte_valid,
   input wire logic cmd_end,
   input wire logic hreadyout,
   input wire logic hresp
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_on_request:
   assert property (local_out_on && !local_out_off && interlock_closed
      |=> output_on_ind) else $error("output did not switch on");
   a_off_request:
   assert property (local_out_off |=> !output_on_ind)
      else $error("output did not switch off");
   a_loop_gate:
   assert property (!interlock_closed |=> !output_on_ind)
      else $error("output on with interlock open");
   a_never_both:
   assert property (!(pass_contact && fail_contact))
      else $error("pass and fail closed together");
   a_start_clears:
   assert property ($rose(busy_contact) |-> !pass_contact && !fail_contact)
      else $error("result contact closed at test start");
   a_pass_close:
   assert property ($rose(pass_contact) |-> $fell(busy_contact))
      else $error("pass closed outside test end");
   a_fail_close:
   assert property ($rose(fail_contact) |-> $fell(busy_contact))
      else $error("fail closed outside test end");
   a_result_hold:
   assert property ($fell(pass_contact) || $fell(fail_contact)
      |-> $rose(busy_contact)) else $error("result opened early");
   a_busy_end:
   assert property ($fell(busy_contact) |-> pass_contact ^ fail_contact)
      else $error("test ended without one result");
   a_start_bit:
   assert property ($fell(txd) |-> (!txd) [*8])
      else $error("start bit too short");
   a_lf_end:
   assert property (cmd_end |-> cmd_byte_valid && cmd_byte == 8'h0A)
      else $error("command end without line feed");
   a_bus_okay:
   assert property (hreadyout && !hresp) else $error("bus not ready");
   // Main scenarios reached.
   c_pass: cover property ($rose(pass_contact));
   c_fail: cover property ($rose(fail_contact));
   c_lf: cover property (cmd_end);
   c_reply: cover property ($fell(txd));
endmodule
bind tsoi_top tsoi_top_sva chk (.clk(clk), .reset_n(reset_n),
   .local_out_on(local_out_on), .local_out_off(local_out_off),
   .interlock_closed(interlock_closed), .output_on_ind(output_on_ind),
   .pass_contact(pass_contact), .fail_contact(fail_contact),
   .busy_contact(busy_contact), .txd(txd), .cmd_byte(cmd_byte),
   .cmd_byte_valid(cmd_byte_valid), .cmd_end(cmd_end),
   .hreadyout(hreadyout), .hresp(hresp));
